// ### prio_bank_regs.vh
// Purpose: register offsets, field positions and reset values of the priority bank
// Assumes: 8-bit word address, 16-bit data, one register per address
// Notes: definitions only
`ifndef PRIO_BANK_REGS_VH
`define PRIO_BANK_REGS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define ADDR_W 8
`define DATA_W 16
`define PRIO_W 3
`define LEVEL_W 4
`define NUM_SRC 10

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_PRIO_I2C2 8'h0C
`define ADDR_PRIO_EXT_IRQ 8'h0D
`define ADDR_PRIO_CALENDAR 8'h0F
`define ADDR_PRIO_ERRORS 8'h10
`define ADDR_PRIO_LOW_VOLTAGE 8'h12
`define ADDR_PRIO_CHARGE_TIMER 8'h13
`define ADDR_CPU_LEVEL 8'h20
`define ADDR_PENDING 8'h21
`define ADDR_REQUEST 8'h22

// ----------------------------------------------------------------
// field low-bit positions
// ----------------------------------------------------------------
`define LSB_I2C2_MASTER 8
`define LSB_I2C2_SLAVE 4
`define LSB_EXT_IRQ4 8
`define LSB_EXT_IRQ3 4
`define LSB_CALENDAR 8
`define LSB_CHECKSUM 12
`define LSB_SERIAL2 8
`define LSB_SERIAL1 4
`define LSB_LOW_VOLTAGE 0
`define LSB_CHARGE_TIMER 4
`define LSB_CPU_REQUEST 15

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define PRIO_RESET 3'h4
`define PRIO_DISABLED 3'h0
`define LEVEL_RESET 4'h0

`endif

// ### prio_field.v
// Purpose: one 3-bit priority field
// Assumes: write enable already decoded by the caller
// Notes: plain storage, no side effects
`timescale 1ns/1ps
`default_nettype none
`include "prio_bank_regs.vh"

module prio_field
(
    // clock and reset
    input wire MCLK,
    input wire SYS_RST,
    // write side
    input wire wr_en,
    input wire [2:0] wr_value,
    // stored field
    output reg [2:0] value
);

    always @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            value <= `PRIO_RESET;
        end
        else if (wr_en)
        begin
            value <= wr_value;
        end
    end

endmodule // prio_field
`default_nettype wire

// ### pending_flag.v
// Purpose: sticky pending flag for one source
// Assumes: set and clear are same-clock pulses
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ps
`default_nettype none

module pending_flag
(
    // clock and reset
    input wire MCLK,
    input wire SYS_RST,
    // control
    input wire set,
    input wire clr,
    // state
    output reg flag
);

    always @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            flag <= 1'b0;
        end
        else if (set)
        begin
            flag <= 1'b1;
        end
        else if (clr)
        begin
            flag <= 1'b0;
        end
    end

endmodule // pending_flag
`default_nettype wire

// ### interrupt_priority_bank.v
// Purpose: bank of per-source 3-bit interrupt priority fields with request gating
// Assumes: source events come from logic on MCLK; software uses a plain strobe port
// Notes: arbitration and vector generation live elsewhere
//
// Contract
// RULE_01: code 111 gives the source level 7, the highest.
// RULE_02: code 000 disables the source; it never requests.
// RULE_03: code 001 is level 1; codes between map linearly to 2..6.
// RULE_04: bits outside priority fields read as zero.
// RULE_05: reset loads every priority field with 100, level 4.
// RULE_06: i2c2 register: master field bits 10..8, slave field bits 6..4.
// RULE_07: external register: irq4 field bits 10..8, irq3 field bits 6..4.
// RULE_08: calendar register: alarm field bits 10..8, rest unimplemented.
// RULE_09: errors register: checksum 14..12, serial2 10..8, serial1 6..4.
// RULE_10: low-voltage register: field bits 2..0, bits 15..3 read zero.
// RULE_11: charge-timer register: field bits 6..4, all other bits unimplemented.
// RULE_12: request with priority not above cpu level stays pending, unacknowledged.
// RULE_13: writes to unimplemented bits are ignored and read back zero.
// RULE_14: priority fields are plain 3-bit values, no effect on pending flags; here code 000 keeps a source's pending flag from setting.
`timescale 1ns/1ps
`default_nettype none
`include "prio_bank_regs.vh"

module interrupt_priority_bank
(
    // clock and reset
    input wire MCLK,
    input wire SYS_RST,
    // register port
    input wire [7:0] ADDR,
    input wire [15:0] WR_DATA,
    input wire WR_EN,
    input wire RD_EN,
    output reg [15:0] RD_DATA,
    // interrupt sources
    input wire [9:0] SRC_EVENT,
    // towards the cpu
    output wire [9:0] SRC_REQUEST,
    output wire CPU_REQUEST,
    output reg [2:0] REQ_LEVEL
);

    // ----------------------------------------------------------------
    // field map
    // ----------------------------------------------------------------
    // source order: 0 i2c2 master, 1 i2c2 slave, 2 ext irq4, 3 ext irq3,
    // 4 calendar, 5 checksum, 6 serial2, 7 serial1, 8 low voltage, 9 charge timer
    function [7:0] field_addr;
        input integer idx;
        begin
            case (idx)
                0: field_addr = `ADDR_PRIO_I2C2;
                1: field_addr = `ADDR_PRIO_I2C2;
                2: field_addr = `ADDR_PRIO_EXT_IRQ;
                3: field_addr = `ADDR_PRIO_EXT_IRQ;
                4: field_addr = `ADDR_PRIO_CALENDAR;
                5: field_addr = `ADDR_PRIO_ERRORS;
                6: field_addr = `ADDR_PRIO_ERRORS;
                7: field_addr = `ADDR_PRIO_ERRORS;
                8: field_addr = `ADDR_PRIO_LOW_VOLTAGE;
                9: field_addr = `ADDR_PRIO_CHARGE_TIMER;
                default: field_addr = 8'hFF;
            endcase
        end
    endfunction

    function integer field_lsb;
        input integer idx;
        begin
            case (idx)
                0: field_lsb = `LSB_I2C2_MASTER; // see RULE_06
                1: field_lsb = `LSB_I2C2_SLAVE; // see RULE_06
                2: field_lsb = `LSB_EXT_IRQ4; // see RULE_07
                3: field_lsb = `LSB_EXT_IRQ3; // see RULE_07
                4: field_lsb = `LSB_CALENDAR; // see RULE_08
                5: field_lsb = `LSB_CHECKSUM; // see RULE_09
                6: field_lsb = `LSB_SERIAL2; // see RULE_09
                7: field_lsb = `LSB_SERIAL1; // see RULE_09
                8: field_lsb = `LSB_LOW_VOLTAGE; // see RULE_10
                9: field_lsb = `LSB_CHARGE_TIMER; // see RULE_11
                default: field_lsb = 0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    wire [29:0] prio_flat;
    wire [9:0] pending;
    wire [9:0] eligible;
    reg [3:0] cpu_level;
    reg [15:0] next_rd_data;
    reg [2:0] next_req_level;
    integer i;
    integer j;

    wire wr_pending = WR_EN && (ADDR == `ADDR_PENDING);

    // ----------------------------------------------------------------
    // per-source fields, flags and gating
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `NUM_SRC; g = g + 1)
        begin : src
            localparam [7:0] FA = field_addr(g);
            localparam integer FL = field_lsb(g);
            wire [2:0] prio = prio_flat[3*g+2:3*g];

            // only the field's own three bits are taken from the write
            prio_field u_field
            (
                .MCLK(MCLK),
                .SYS_RST(SYS_RST), // see RULE_05
                .wr_en(WR_EN && (ADDR == FA)), // see RULE_13
                .wr_value(WR_DATA[FL+2:FL]), // see RULE_14
                .value(prio_flat[3*g+2:3*g])
            );

            // a disabled source never latches, so enabling later
            // does not release a stale event
            pending_flag u_pend
            (
                .MCLK(MCLK),
                .SYS_RST(SYS_RST),
                .set(SRC_EVENT[g] && (prio != `PRIO_DISABLED)), // see RULE_02
                .clr(wr_pending && WR_DATA[g]),
                .flag(pending[g])
            );

            // strict greater-than: equal level is held off
            assign eligible[g] = pending[g] && (prio != `PRIO_DISABLED) && // see RULE_02
                                 ({1'b0, prio} > cpu_level); // see RULE_12
        end
    endgenerate

    assign SRC_REQUEST = eligible;
    assign CPU_REQUEST = |eligible; // see RULE_12

    // ----------------------------------------------------------------
    // cpu priority level
    // ----------------------------------------------------------------
    always @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            cpu_level <= `LEVEL_RESET;
        end
        else if (WR_EN && (ADDR == `ADDR_CPU_LEVEL))
        begin
            cpu_level <= WR_DATA[3:0];
        end
    end

    // ----------------------------------------------------------------
    // highest requesting level
    // ----------------------------------------------------------------
    // codes are levels directly: 001 lowest, 111 highest
    always @*
    begin
        next_req_level = `PRIO_DISABLED;
        for (i = 0; i < `NUM_SRC; i = i + 1)
        begin
            if (eligible[i] && (prio_flat[3*i +: 3] > next_req_level)) // see RULE_01
            begin
                next_req_level = prio_flat[3*i +: 3]; // see RULE_03
            end
        end
    end

    always @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            REQ_LEVEL <= `PRIO_DISABLED;
        end
        else
        begin
            REQ_LEVEL <= next_req_level;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // unmapped addresses and unused bits fall through as zero
    always @*
    begin
        next_rd_data = 16'h0000;
        for (j = 0; j < `NUM_SRC; j = j + 1)
        begin
            if (ADDR == field_addr(j))
            begin
                next_rd_data = next_rd_data | ({13'h0, prio_flat[3*j +: 3]} << field_lsb(j)); // see RULE_04
            end
        end
        case (ADDR)
            `ADDR_CPU_LEVEL:
            begin
                next_rd_data = {12'h000, cpu_level};
            end
            `ADDR_PENDING:
            begin
                next_rd_data = {6'h0, pending};
            end
            `ADDR_REQUEST:
            begin
                next_rd_data = {CPU_REQUEST, 5'h0, eligible};
            end
            default:
            begin
                next_rd_data = next_rd_data;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            RD_DATA <= 16'h0000;
        end
        else if (RD_EN)
        begin
            RD_DATA <= next_rd_data; // see RULE_13
        end
        else
        begin
            RD_DATA <= 16'h0000;
        end
    end

endmodule // interrupt_priority_bank
`default_nettype wire

// ### interrupt_priority_bank_sva.sv
// Purpose: port-level checks of the priority bank
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind below
`timescale 1ns/1ps
`default_nettype none

module interrupt_priority_bank_sva
(
    // clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [15:0] RD_DATA,
    // sources and requests
    input wire logic [9:0] SRC_EVENT,
    input wire logic [9:0] SRC_REQUEST,
    input wire logic CPU_REQUEST,
    input wire logic [2:0] REQ_LEVEL
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence rd_at(logic [7:0] a);
        RD_EN && ADDR == a;
    endsequence
    // event lands the cycle after its field was zeroed, no write in between
    sequence lv_turned_off;
        WR_EN && ADDR == 8'h12 && WR_DATA[2:0] == 3'h0 ##1 SRC_EVENT[8] && !WR_EN;
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    i2c_gaps_a: assert property (rd_at(8'h0C) |=> (RD_DATA & 16'hF88F) == 16'h0000)
        else $error("i2c register unused bits set");
    ext_gaps_a: assert property (rd_at(8'h0D) |=> (RD_DATA & 16'hF88F) == 16'h0000)
        else $error("external register unused bits set");
    cal_gaps_a: assert property (rd_at(8'h0F) |=> (RD_DATA & 16'hF8FF) == 16'h0000)
        else $error("calendar register unused bits set");
    err_gaps_a: assert property (rd_at(8'h10) |=> (RD_DATA & 16'h888F) == 16'h0000)
        else $error("errors register unused bits set");
    lv_gaps_a: assert property (rd_at(8'h12) |=> (RD_DATA & 16'hFFF8) == 16'h0000)
        else $error("low voltage register unused bits set");
    ct_gaps_a: assert property (rd_at(8'h13) |=> (RD_DATA & 16'hFF8F) == 16'h0000)
        else $error("charge timer register unused bits set");
    rd_idle_a: assert property (!RD_EN |=> RD_DATA == 16'h0000)
        else $error("read data outside its slot");
    cpu_or_a: assert property (CPU_REQUEST == (|SRC_REQUEST))
        else $error("cpu request differs from source requests");
    idle_level_a: assert property (!CPU_REQUEST |=> REQ_LEVEL == 3'h0)
        else $error("level without request");
    busy_level_a: assert property (CPU_REQUEST |=> REQ_LEVEL != 3'h0)
        else $error("request with level zero");
    lv_off_a: assert property (lv_turned_off |=> !SRC_REQUEST[8])
        else $error("disabled source requested");
    stat_read_a: assert property (rd_at(8'h22) |=> RD_DATA == {$past(CPU_REQUEST), 5'h0, $past(SRC_REQUEST)})
        else $error("request status read differs from request outputs");
endmodule // interrupt_priority_bank_sva

bind interrupt_priority_bank interrupt_priority_bank_sva checker_i (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
    .SRC_EVENT(SRC_EVENT), .SRC_REQUEST(SRC_REQUEST), .CPU_REQUEST(CPU_REQUEST), .REQ_LEVEL(REQ_LEVEL));
`default_nettype wire

// ### interrupt_priority_bank_bench.sv
// Purpose: self-checking bench of the priority bank
// Assumes: register map as handed over
// Notes: single clock, no random stimulus
`timescale 1ns/1ps
`default_nettype none

module interrupt_priority_bank_bench;
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [7:0] ADDR = 8'h00;
    logic [15:0] WR_DATA = 16'h0000;
    logic WR_EN = 1'b0;
    logic RD_EN = 1'b0;
    logic [9:0] SRC_EVENT = 10'h000;
    logic [15:0] RD_DATA;
    logic [9:0] SRC_REQUEST;
    logic CPU_REQUEST;
    logic [2:0] REQ_LEVEL;
    int err_total = 0;
    int compares = 0;
    logic [7:0] regs [6] = '{8'h0C, 8'h0D, 8'h0F, 8'h10, 8'h12, 8'h13};
    logic [15:0] masks [6] = '{16'h0770, 16'h0770, 16'h0700, 16'h7770, 16'h0007, 16'h0070};
    logic [7:0] src_reg [10] = '{8'h0C, 8'h0C, 8'h0D, 8'h0D, 8'h0F, 8'h10, 8'h10, 8'h10, 8'h12, 8'h13};
    int src_lsb [10] = '{8, 4, 8, 4, 8, 12, 8, 4, 0, 4};

    always #4 MCLK = ~MCLK;

    interrupt_priority_bank DUT (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .SRC_EVENT(SRC_EVENT),
        .SRC_REQUEST(SRC_REQUEST), .CPU_REQUEST(CPU_REQUEST), .REQ_LEVEL(REQ_LEVEL));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WR_DATA <= d;
        WR_EN <= 1'b1;
        @(posedge MCLK);
        WR_EN <= 1'b0;
    endtask

    // read data only stands in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge MCLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge MCLK);
        RD_EN <= 1'b0;
        #1 chk(RD_DATA, exp);
    endtask

    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        logic [2:0] c;
        repeat (5) @(posedge MCLK);
        SYS_RST <= 1'b0;
        for (int k = 0; k < 6; k++)
            rd(regs[k], masks[k] & 16'h4444);
        $display("test reset values done");
        for (int k = 0; k < 6; k++)
        begin
            wr(regs[k], 16'hFFFF);
            rd(regs[k], masks[k]);
            for (int v = 0; v < 8; v++)
            begin
                wr(regs[k], 16'h1111 * 16'(v));
                rd(regs[k], masks[k] & (16'h1111 * 16'(v)));
            end
        end
        wr(8'h0E, 16'hFFFF);
        rd(8'h0E, 16'h0000);
        $display("test field access done");
        // every source once, codes 0..7 spread over them
        for (int i = 0; i < 10; i++)
        begin
            c = 3'(i % 8);
            wr(8'h21, 16'h03FF);
            wr(src_reg[i], 16'(c) << src_lsb[i]);
            SRC_EVENT <= 10'h001 << i;
            @(posedge MCLK);
            SRC_EVENT <= 10'h000;
            #1 chk(16'(SRC_REQUEST), c != 3'h0 ? 16'h0001 << i : 16'h0000);
            @(posedge MCLK);
            #1 chk(16'(REQ_LEVEL), 16'(c));
        end
        $display("test source levels done");
        // event while disabled must not survive a later enable
        wr(8'h21, 16'h03FF);
        wr(8'h12, 16'h0000);
        SRC_EVENT <= 10'h100;
        @(posedge MCLK);
        SRC_EVENT <= 10'h000;
        wr(8'h12, 16'h0007);
        rd(8'h21, 16'h0000);
        wr(8'h21, 16'h03FF);
        wr(8'h12, 16'h0003);
        wr(8'h20, 16'h0003);
        SRC_EVENT <= 10'h100;
        @(posedge MCLK);
        SRC_EVENT <= 10'h000;
        rd(8'h22, 16'h0000);
        chk(16'(CPU_REQUEST), 16'h0000);
        rd(8'h21, 16'h0100);
        wr(8'h12, 16'h0002);
        rd(8'h21, 16'h0100);
        wr(8'h12, 16'h0007);
        rd(8'h22, 16'h8100);
        chk(16'(REQ_LEVEL), 16'h0007);
        chk(16'(CPU_REQUEST), 16'h0001);
        $display("test cpu level gating done");
        // second reset in mid-run reloads the fields and drops the request
        @(posedge MCLK);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        SYS_RST <= 1'b0;
        rd(8'h12, 16'h0004);
        rd(8'h10, 16'h4440);
        rd(8'h22, 16'h0000);
        chk(16'(CPU_REQUEST), 16'h0000);
        $display("test mid reset done");
        close_out();
    end

    // whole run is under 2000 cycles
    initial
    begin
        #100000;
        err_total++;
        close_out();
    end
endmodule // interrupt_priority_bank_bench
`default_nettype wire
